// file: src/ast_pkg.sv
package ast_pkg;
  // ==========================================================
  // sizes
  localparam int NUM_ENG = 4;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int RATE_W = 16;
  localparam int CNT_W = 24;
  localparam int PC_W = 4;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SYNC_PULSE_NS = 100;
  localparam int START_PULSE_NS = 100;
  localparam int SYNC_PULSE_CYC =
    (SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_PULSE_CYC =
    (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // register offsets, engine i sits at ENG_BASE + 4*i
  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_CMD = 8'h04;
  localparam logic [AW-1:0] REG_MIN_DLY = 8'h08;
  localparam logic [AW-1:0] REG_STATUS = 8'h0c;
  localparam logic [AW-1:0] REG_ENG_BASE = 8'h10;
  // ==========================================================
  // field positions
  localparam int CTRL_CLK_BP = 0;
  localparam int CTRL_SYNC_MST = 1;
  localparam int CTRL_START_MST = 2;
  localparam int CTRL_TRIG_FALL = 3;
  localparam int CTRL_TRIG_FRONT = 4;
  localparam int CTRL_W = 5;
  localparam int CMD_COMMIT = 0;
  localparam int CMD_START = 1;
  localparam int ENG_EN = 0;
  localparam int ENG_SGL_PT = 1;
  localparam int ENG_RATE_LSB = 16;
  localparam int ST_ACC_PRES = 0;
  localparam int ST_ACC_CHG = 1;
  localparam int ST_SYNC_SEEN = 2;
  localparam int ST_SYNC_WAIT = 3;
  localparam int ST_START_WAIT = 4;
  localparam int ST_ARMED_LSB = 8;
  localparam int ST_RUN_LSB = 12;
  // synchroniser slots
  localparam int SI_REF = 0;
  localparam int SI_SYNC = 1;
  localparam int SI_START = 2;
  localparam int SI_FRONT = 3;
  localparam int SI_ACC = 4;
  localparam int SI_W = 5;
  // ==========================================================
  // reset values and group delay model
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [RATE_W-1:0] RATE_RST = 16'h0001;
  localparam logic [RATE_W-1:0] MIN_DLY_RST = 16'h0000;
  localparam logic [CNT_W-1:0] GD_BASE_TICKS = 24'h000040;
  localparam logic [CNT_W-1:0] GD_PER_RATE = 24'h000020;

  typedef enum logic [2:0] {
    E_IDLE, E_SETTLE, E_ARMED, E_FILL, E_RUN
  } ast_eng_state_t;

  // group delay in oversample ticks, longer for a bigger rate divisor
  function automatic logic [CNT_W-1:0] gd_ticks(
    input logic [RATE_W-1:0] rate
  );
    gd_ticks = GD_BASE_TICKS + CNT_W'(rate) * GD_PER_RATE;
  endfunction
endpackage

// file: src/ast_eng_if.sv
interface ast_eng_if;
  import ast_pkg::*;
  logic os_tick;
  logic sync_evt;
  logic trig_evt;
  logic en;
  logic sp_mode;
  logic [RATE_W-1:0] rate;
  logic armed;
  logic running;
  logic buf_stb;
  logic sp_stb;
  modport top (output os_tick, sync_evt, trig_evt, en, sp_mode, rate,
               input armed, running, buf_stb, sp_stb);
  modport eng (input os_tick, sync_evt, trig_evt, en, sp_mode, rate,
               output armed, running, buf_stb, sp_stb);
endinterface

// file: src/ast_engine.sv
module ast_engine import ast_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control and stream strobes
  ast_eng_if.eng bus
);
  ast_eng_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic armed_q, run_q, buf_q, sp_q;

  // ==========================================================
  // decode
  wire logic [RATE_W-1:0] rate_eff =
    (bus.rate == '0) ? RATE_W'(1) : bus.rate;
  wire logic [CNT_W-1:0] gd_now = gd_ticks(rate_eff);
  wire logic cnt_end = bus.os_tick && (cnt_q == CNT_W'(1));
  wire logic fire = ((state_q == E_FILL) || (state_q == E_RUN)) &&
    cnt_end && bus.en && !bus.sync_evt;

  // next state: settle after sync, wait trigger, fill, run
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (bus.os_tick && (cnt_q != '0)) begin
      cnt_d = cnt_q - CNT_W'(1);
    end
    case (state_q)
      E_IDLE: begin
      end
      E_SETTLE: begin
        if (cnt_end) begin
          state_d = E_ARMED;
        end
      end
      E_ARMED: begin
        if (bus.trig_evt) begin
          state_d = E_FILL; // trigger lines up with the filter output
          cnt_d = gd_now;
        end
      end
      E_FILL: begin
        if (cnt_end) begin
          state_d = E_RUN;
          cnt_d = CNT_W'(rate_eff);
        end
      end
      E_RUN: begin
        if (cnt_end) begin
          cnt_d = CNT_W'(rate_eff);
        end
      end
      default: state_d = E_IDLE;
    endcase
    if (bus.sync_evt) begin
      state_d = E_SETTLE; // wait a full group delay after sync
      cnt_d = gd_now;
    end
    if (!bus.en) begin
      state_d = E_IDLE;
      cnt_d = '0;
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= E_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // flags and stream strobes
  always_ff @(posedge clk) begin
    if (reset) begin
      armed_q <= 1'b0;
      run_q <= 1'b0;
      buf_q <= 1'b0;
      sp_q <= 1'b0;
    end else begin
      armed_q <= (state_d == E_ARMED);
      run_q <= (state_d == E_FILL) || (state_d == E_RUN);
      buf_q <= fire && !bus.sp_mode;
      sp_q <= fire && bus.sp_mode;
    end
  end

  assign bus.armed = armed_q;
  assign bus.running = run_q;
  assign bus.buf_stb = buf_q;
  assign bus.sp_stb = sp_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_fill_end;
    state_q == E_FILL && cnt_end && bus.en && !bus.sync_evt;
  endsequence

  a_trig_not_armed: assert property (
    (bus.trig_evt && state_q != E_ARMED && state_q != E_FILL &&
     state_q != E_RUN) |=> state_q != E_FILL)
    else $error("trigger taken before group delay passed");
  a_first_sample_gd: assert property (
    s_fill_end |=> (buf_q || sp_q) && state_q == E_RUN)
    else $error("first sample not at end of group delay");
  a_trig_load_gd: assert property (
    (state_q == E_ARMED && bus.trig_evt && bus.en && !bus.sync_evt)
    |=> state_q == E_FILL && cnt_q == gd_ticks($past(rate_eff)))
    else $error("fill wait not one group delay");
  a_stream_pick: assert property (
    (buf_q || sp_q) |-> (buf_q != sp_q) && (sp_q == $past(bus.sp_mode)))
    else $error("sample sent on wrong stream");
  a_settle_armed: assert property (
    (state_q == E_SETTLE && cnt_end && bus.en && !bus.sync_evt)
    |=> armed_q)
    else $error("armed not raised when wait expired");
endmodule // ast_engine

// file: src/ast_top.sv
// Operation
// - trigger placed at its true time, filter group delay compensated.
// - after sync, start trigger ignored until one group delay elapsed.
// - first sample released one group delay after start trigger.
// - any gap of at least one group delay between sync and start leaves first sample one delay later.
// - group delay grows as sample rate is lowered.
// - backplane source derives oversample clock from backplane reference.
// - sync master drives sync pulse onto a trigger line.
// - sync issued or received resets ADCs and oversample clock phase.
// - sync slaves take sync pulse from master's trigger line.
// - start slaves take start trigger from the start master's line or the front input, by setting.
// - start master holds start until the minimum delay has passed.
// - four timing engines run at once, each with own settings.
// - each engine uses buffered or single point stream by mode.
// - four streams of each type, one per channel.
// - accessory insertion and removal sensed and reported to software.
// - legacy 10 MHz clock is never a reference source.
// - reference is backplane locked or free running internal timebase.
// - start trigger edge selectable rising or falling.
module ast_top import ast_pkg::*; #(
  parameter int INT_REF_DIV = 2,
  parameter int OS_DIV = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [DW-1:0] rdata,
  // backplane reference and trigger lines
  input wire logic backplane_ref_clock_fast,
  input wire logic sync_trig_in,
  output logic sync_trig_out,
  output logic sync_trig_oe,
  input wire logic start_trig_in,
  output logic start_trig_out,
  output logic start_trig_oe,
  // front connector
  input wire logic front_trigger_input,
  input wire logic accessory_present,
  // converter timing
  output logic adc_reset,
  output logic oversample_clk,
  // per channel streams
  output logic [NUM_ENG-1:0] buffered_valid,
  output logic [NUM_ENG-1:0] hw_timed_single_point_valid,
  output logic [NUM_ENG-1:0] trig_armed
);
  // ==========================================================
  // parameter checks
  if (INT_REF_DIV < 1 || INT_REF_DIV > 255) begin : g_chk_int
    $error("INT_REF_DIV out of range");
  end
  if (OS_DIV < 2 || OS_DIV > 255) begin : g_chk_os
    $error("OS_DIV out of range");
  end

  localparam logic [7:0] INT_LAST = 8'(INT_REF_DIV - 1);
  localparam logic [7:0] OS_LAST = 8'(OS_DIV - 1);

  logic [SI_W-1:0] meta_q, sync_q, prev_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [RATE_W-1:0] min_dly_q;
  logic [NUM_ENG-1:0] eng_en_q, eng_hw_q;
  logic [RATE_W-1:0] eng_rate_q [NUM_ENG];
  logic [7:0] int_div_q, os_div_q;
  logic os_clk_q, os_tick_q, adc_rst_q;
  logic [PC_W-1:0] spc_q, stc_q;
  logic sync_drv_q, start_drv_q;
  logic sync_wait_q, sync_seen_q, start_wait_q, start_pend_q;
  logic [RATE_W-1:0] mdly_q;
  logic acc_chg_q;
  logic [DW-1:0] rdata_q;
  logic [NUM_ENG-1:0] armed_w, run_w, buf_w, sp_w;

  // ==========================================================
  // pin synchronisers: slot meta_q feeds only sync_q
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= {accessory_present, front_trigger_input, start_trig_in,
                 sync_trig_in, backplane_ref_clock_fast};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  wire logic [SI_W-1:0] rise = sync_q & ~prev_q;
  wire logic [SI_W-1:0] fall = ~sync_q & prev_q;

  // ==========================================================
  // register decode
  wire logic wr_ctrl = wr_stb && (addr == REG_CTRL);
  wire logic wr_cmd = wr_stb && (addr == REG_CMD);
  wire logic wr_mdly = wr_stb && (addr == REG_MIN_DLY);
  wire logic wr_stat = wr_stb && (addr == REG_STATUS);
  wire logic eng_hit = (addr[AW-1:4] == REG_ENG_BASE[AW-1:4]) &&
    (addr[1:0] == 2'h0);
  wire logic [1:0] eng_idx = addr[3:2];
  wire logic cmd_commit = wr_cmd && wdata[CMD_COMMIT];
  wire logic cmd_start = wr_cmd && wdata[CMD_START];
  wire logic is_sync_mst = ctrl_q[CTRL_SYNC_MST];
  wire logic is_start_mst = ctrl_q[CTRL_START_MST];

  // ==========================================================
  // reference and oversample clock; only backplane or internal exists
  wire logic int_tick = (int_div_q == INT_LAST);
  wire logic ref_tick = ctrl_q[CTRL_CLK_BP] ?
    rise[SI_REF] : int_tick;
  wire logic os_edge = ref_tick && (os_div_q == OS_LAST);

  // sync is issued by the master or taken from the line by a slave
  wire logic sync_issue = cmd_commit && is_sync_mst;
  wire logic sync_take = !is_sync_mst && sync_wait_q &&
    rise[SI_SYNC];
  wire logic sync_evt = sync_issue || sync_take;

  // start trigger: master after min delay, slaves from selected edge
  wire logic trig_src = ctrl_q[CTRL_TRIG_FRONT] ?
    rise[SI_FRONT] : rise[SI_START];
  wire logic trig_src_f = ctrl_q[CTRL_TRIG_FRONT] ?
    fall[SI_FRONT] : fall[SI_START];
  wire logic trig_edge = ctrl_q[CTRL_TRIG_FALL] ?
    trig_src_f : trig_src;
  wire logic start_go = is_start_mst && start_pend_q &&
    (mdly_q == '0);
  wire logic trig_take = !is_start_mst && start_wait_q &&
    trig_edge;
  wire logic trig_evt = start_go || trig_take;

  // timebase counters, phase cleared by sync
  always_ff @(posedge clk) begin
    if (reset) begin
      int_div_q <= '0;
      os_div_q <= '0;
      os_clk_q <= 1'b0;
      os_tick_q <= 1'b0;
      adc_rst_q <= 1'b0;
    end else begin
      int_div_q <= int_tick ? 8'h00 : int_div_q + 8'h01;
      os_tick_q <= os_edge && !sync_evt;
      adc_rst_q <= sync_evt;
      if (sync_evt) begin
        os_div_q <= '0;
        os_clk_q <= 1'b0;
      end else if (ref_tick) begin
        os_div_q <= os_edge ? 8'h00 : os_div_q + 8'h01;
        os_clk_q <= os_edge ? ~os_clk_q : os_clk_q;
      end
    end
  end

  // line pulse counters for sync and start
  always_ff @(posedge clk) begin
    if (reset) begin
      spc_q <= '0;
      stc_q <= '0;
      sync_drv_q <= 1'b0;
      start_drv_q <= 1'b0;
    end else begin
      // drive flags track a nonzero count, so the pins come from flops
      sync_drv_q <= sync_issue || (spc_q > PC_W'(1));
      start_drv_q <= start_go || (stc_q > PC_W'(1));
      if (sync_issue) begin
        spc_q <= PC_W'(SYNC_PULSE_CYC);
      end else if (spc_q != '0) begin
        spc_q <= spc_q - PC_W'(1);
      end
      if (start_go) begin
        stc_q <= PC_W'(START_PULSE_CYC);
      end else if (stc_q != '0) begin
        stc_q <= stc_q - PC_W'(1);
      end
    end
  end

  // handshake flags and min delay counter
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_wait_q <= 1'b0;
      sync_seen_q <= 1'b0;
      start_wait_q <= 1'b0;
      start_pend_q <= 1'b0;
      mdly_q <= '0;
    end else begin
      sync_wait_q <= (cmd_commit && !is_sync_mst) ||
        (sync_wait_q && !sync_take);
      sync_seen_q <= sync_evt || (sync_seen_q && !cmd_commit);
      start_wait_q <= (cmd_start && !is_start_mst) ||
        (start_wait_q && !trig_take);
      start_pend_q <= (cmd_start && is_start_mst) ||
        (start_pend_q && !start_go);
      if (sync_evt) begin
        mdly_q <= min_dly_q;
      end else if (os_tick_q && (mdly_q != '0)) begin
        mdly_q <= mdly_q - RATE_W'(1);
      end
    end
  end

  // accessory change flag, a new change beats the clear
  wire logic acc_edge = rise[SI_ACC] || fall[SI_ACC];
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_chg_q <= 1'b0;
    end else begin
      acc_chg_q <= acc_edge ||
        (acc_chg_q && !(wr_stat && wdata[ST_ACC_CHG]));
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= CTRL_RST;
      min_dly_q <= MIN_DLY_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdata[CTRL_W-1:0];
      end
      if (wr_mdly) begin
        min_dly_q <= wdata[RATE_W-1:0];
      end
    end
  end

  // per engine timing and mode settings
  always_ff @(posedge clk) begin
    if (reset) begin
      eng_en_q <= '0;
      eng_hw_q <= '0;
      for (int i = 0; i < NUM_ENG; i++) begin
        eng_rate_q[i] <= RATE_RST;
      end
    end else if (wr_stb && eng_hit) begin
      eng_en_q[eng_idx] <= wdata[ENG_EN];
      eng_hw_q[eng_idx] <= wdata[ENG_SGL_PT];
      eng_rate_q[eng_idx] <= wdata[ENG_RATE_LSB +: RATE_W];
    end
  end

  // ==========================================================
  // read path
  logic [DW-1:0] status_w, eng_w;
  always_comb begin
    status_w = '0;
    status_w[ST_ACC_PRES] = sync_q[SI_ACC];
    status_w[ST_ACC_CHG] = acc_chg_q;
    status_w[ST_SYNC_SEEN] = sync_seen_q;
    status_w[ST_SYNC_WAIT] = sync_wait_q;
    status_w[ST_START_WAIT] = start_wait_q || start_pend_q;
    status_w[ST_ARMED_LSB +: NUM_ENG] = armed_w;
    status_w[ST_RUN_LSB +: NUM_ENG] = run_w;
    eng_w = '0;
    eng_w[ENG_EN] = eng_en_q[eng_idx];
    eng_w[ENG_SGL_PT] = eng_hw_q[eng_idx];
    eng_w[ENG_RATE_LSB +: RATE_W] = eng_rate_q[eng_idx];
  end

  wire logic [DW-1:0] rd_mux =
    (addr == REG_CTRL) ? DW'(ctrl_q) :
    (addr == REG_MIN_DLY) ? DW'(min_dly_q) :
    (addr == REG_STATUS) ? status_w :
    eng_hit ? eng_w : '0;

  // read data in the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_stb ? rd_mux : '0;
    end
  end

  // ==========================================================
  // four engines, engine i serves channel i
  ast_eng_if eif [NUM_ENG] ();
  for (genvar g = 0; g < NUM_ENG; g++) begin : g_eng
    assign eif[g].os_tick = os_tick_q;
    assign eif[g].sync_evt = sync_evt;
    assign eif[g].trig_evt = trig_evt;
    assign eif[g].en = eng_en_q[g];
    assign eif[g].sp_mode = eng_hw_q[g];
    assign eif[g].rate = eng_rate_q[g];
    assign armed_w[g] = eif[g].armed;
    assign run_w[g] = eif[g].running;
    assign buf_w[g] = eif[g].buf_stb;
    assign sp_w[g] = eif[g].sp_stb;
    ast_engine u_eng (
      .clk(clk),
      .reset(reset),
      .bus(eif[g])
    );
  end

  // ==========================================================
  // outputs
  assign rdata = rdata_q;
  assign sync_trig_out = sync_drv_q;
  assign sync_trig_oe = sync_drv_q;
  assign start_trig_out = start_drv_q;
  assign start_trig_oe = start_drv_q;
  assign adc_reset = adc_rst_q;
  assign oversample_clk = os_clk_q;
  assign buffered_valid = buf_w;
  assign hw_timed_single_point_valid = sp_w;
  assign trig_armed = armed_w;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_sync_pulse_out: assert property (
    sync_issue |=> (sync_trig_oe && sync_trig_out) [*4] ##1 !sync_trig_oe)
    else $error("sync pulse wrong length");
  a_sync_resets_adc: assert property (
    sync_evt |=> adc_rst_q && os_div_q == '0 && !os_clk_q)
    else $error("sync did not reset converter timing");
  a_slave_sync_line: assert property (
    (!is_sync_mst && sync_wait_q && rise[SI_SYNC] && !cmd_commit) |=>
    !sync_wait_q && sync_seen_q && mdly_q == $past(min_dly_q))
    else $error("slave missed sync from line");
  a_start_master: assert property (
    start_go |=> start_trig_oe [*4] ##1 !start_trig_oe)
    else $error("start pulse wrong length");
  a_min_delay: assert property (
    $rose(start_trig_oe) |-> $past(mdly_q) == '0)
    else $error("start issued before minimum delay");
  a_trig_edge_pol: assert property (
    (!is_start_mst && start_wait_q && !wr_cmd &&
     (ctrl_q[CTRL_TRIG_FALL] ? !trig_src_f : !trig_src)) |=> start_wait_q)
    else $error("start taken on wrong edge");
  a_ref_backplane: assert property (
    (ctrl_q[CTRL_CLK_BP] && !rise[SI_REF] && !sync_evt && !wr_ctrl)
    |=> $stable(os_div_q))
    else $error("oversample divider moved without reference edge");
  a_acc_change: assert property (
    acc_edge |=> acc_chg_q ##1
    (acc_chg_q || $past(wr_stat && wdata[ST_ACC_CHG])))
    else $error("accessory change not flagged");
endmodule // ast_top

// file: dv/ast_bp_peer.sv
module ast_bp_peer (
  // backplane lines
  output logic ref_clk,
  output logic sync_lvl,
  output logic start_lvl,
  // front connector
  output logic acc
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // backplane reference, free running
  initial begin
    ref_clk = 1'b0;
    forever #100 ref_clk = ~ref_clk;
  end
  // idle levels of the peer lines
  initial begin
    sync_lvl = 1'b0;
    start_lvl = 1'b0;
    acc = 1'b0;
  end
  // slow backplane clocks, edges on reference rising edges
  int ph = 0;
  logic backplane_sync_clock_slow = 1'b0;
  logic legacy_backplane_clock_slow = 1'b0;
  always @(posedge ref_clk) begin
    ph = (ph == 9) ? 0 : ph + 1;
    backplane_sync_clock_slow = (ph == 0); // 10% duty
    legacy_backplane_clock_slow = (ph < 5); // in phase
  end
  // sync pulse of a peer sync master, 100 ns wide
  task automatic sync_pulse;
    sync_lvl <= 1'b1;
    #100 sync_lvl <= 1'b0;
  endtask
endmodule // ast_bp_peer

// file: dv/tb.sv
module tb import ast_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // signals
  localparam logic [DW-1:0] ALL = 32'hffffffff;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [AW-1:0] addr = 8'h00;
  logic [DW-1:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [DW-1:0] rdata;
  logic ref_clk, p_sync, p_start, acc;
  logic sync_out, sync_oe, start_out, start_oe, adc_reset, osc;
  logic [NUM_ENG-1:0] buf_v, sp_v, armed, arm_q;
  logic [NUM_ENG-1:0] sp_mode = 4'h0;
  logic front = 1'b0;
  logic osc_q, oe_q;
  int n_errors, compares, os_n, t_sync, t_trig, n_adc, n_oe, n_lvl;
  int t_arm[NUM_ENG], t_first[NUM_ENG], n_bad[NUM_ENG];
  int gd[$];
  // a driven line shows our level, else the peer's
  wire sync_line = sync_oe ? sync_out : p_sync;
  wire start_line = start_oe ? start_out : p_start;

  // clock, 25 ns
  initial begin
    forever #12.5 clk = ~clk;
  end

  ast_bp_peer peer (.ref_clk(ref_clk), .sync_lvl(p_sync),
    .start_lvl(p_start), .acc(acc));

  ast_top #(.INT_REF_DIV(1), .OS_DIV(2)) dut (.clk(clk),
    .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .backplane_ref_clock_fast(ref_clk),
    .sync_trig_in(sync_line), .sync_trig_out(sync_out),
    .sync_trig_oe(sync_oe), .start_trig_in(start_line),
    .start_trig_out(start_out), .start_trig_oe(start_oe),
    .front_trigger_input(front), .accessory_present(acc),
    .adc_reset(adc_reset), .oversample_clk(osc),
    .buffered_valid(buf_v), .hw_timed_single_point_valid(sp_v),
    .trig_armed(armed));

  // ==========================================
  // model: event times in oversample ticks
  always @(negedge clk) begin
    if (osc !== osc_q) os_n++;
    osc_q = osc;
    if (reset === 1'b0) begin
      if (adc_reset === 1'b1) begin
        n_adc++;
        t_sync = os_n;
      end
      if (start_oe === 1'b1 && oe_q !== 1'b1) t_trig = os_n;
      if (sync_oe === 1'b1) n_oe++;
      if (sync_out !== sync_oe || start_out !== start_oe) n_lvl++;
      for (int i = 0; i < NUM_ENG; i++) begin
        if (armed[i] === 1'b1 && arm_q[i] !== 1'b1) t_arm[i] = os_n;
        if ((buf_v[i] | sp_v[i]) === 1'b1 && t_first[i] < 0)
          t_first[i] = os_n;
        if ((sp_mode[i] ? buf_v[i] : sp_v[i]) !== 1'b0) n_bad[i]++;
      end
    end
    oe_q = start_oe;
    arm_q = armed;
  end

  // ==========================================
  // checks and bus cycles
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic near(input int got, input int exp);
    chk(DW'((got - exp) inside {[-1:1]}), 32'h1);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] m,
                    input logic [DW-1:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e);
  endtask
  task automatic wait_for(input bit first);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    while (!done && n < 8000) begin
      @(negedge clk);
      n++;
      done = 1'b1;
      foreach (t_arm[i]) if ((first ? t_first[i] : t_arm[i]) < 0) done = 0;
    end
    chk(DW'(done), 32'h1);
  endtask
  task automatic check_eng;
    foreach (t_arm[i]) begin
      near(t_arm[i] - t_sync, gd[i]);
      near(t_first[i] - t_trig, gd[i]);
      chk(DW'(n_bad[i]), 32'h0);
    end
    chk(DW'(t_arm[1] > t_arm[0]), 32'h1);
    chk(DW'(n_oe), DW'(SYNC_PULSE_CYC));
    chk(DW'(n_lvl), 32'h0);
  endtask
  task automatic conclude;
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    int rate, n0;
    void'($urandom(7593));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    rd(REG_CTRL, ALL, 32'h0);
    rd(REG_MIN_DLY, ALL, 32'h0);
    rd(REG_ENG_BASE, ALL, 32'h00010000);
    rd(REG_CMD, ALL, 32'h0);
    rd(8'hfc, ALL, 32'h0);
    // four engines, mixed modes and rates
    for (int i = 0; i < NUM_ENG; i++) begin
      rate = (i < 2) ? i + 1 : 1 + int'($urandom % 2);
      sp_mode[i] = i[0];
      gd.push_back(int'(GD_BASE_TICKS) + int'(GD_PER_RATE) * rate);
      wr(REG_ENG_BASE + AW'(4 * i), {rate[15:0], 14'h0, sp_mode[i], 1'b1});
      t_arm[i] = -1;
      t_first[i] = -1;
    end
    rd(REG_ENG_BASE + 8'h04, ALL, 32'h00020003);
    // internal timebase: one toggle per INT_REF_DIV * OS_DIV clocks
    n0 = os_n;
    repeat (40) @(posedge clk);
    near(os_n - n0, 20);
    // master: sync now, start held back by the minimum delay
    wr(REG_MIN_DLY, 32'h000000c8);
    wr(REG_CTRL, 32'h00000007);
    wr(REG_CMD, 32'h00000001);
    wr(REG_CMD, 32'h00000002);
    wait_for(1'b1);
    chk(DW'(n_adc), 32'h1);
    near(t_trig - t_sync, 200);
    check_eng();
    // slave: sync from the line, start on a falling front edge
    wr(REG_CTRL, 32'h00000019);
    peer.sync_pulse();
    repeat (8) @(posedge clk);
    chk(DW'(n_adc), 32'h1);
    foreach (t_arm[i]) t_arm[i] = -1;
    wr(REG_CMD, 32'h00000001);
    peer.sync_pulse();
    wait_for(1'b0);
    foreach (t_first[i]) t_first[i] = -1;
    wr(REG_CMD, 32'h00000002);
    front <= 1'b1;
    peer.start_lvl <= 1'b1;
    repeat (20) @(posedge clk);
    peer.start_lvl <= 1'b0;
    repeat (20) @(posedge clk);
    chk(DW'(armed), 32'hf);
    front <= 1'b0;
    t_trig = os_n;
    wait_for(1'b1);
    chk(DW'(n_adc), 32'h2);
    check_eng();
    // accessory insert and removal
    peer.acc = 1'b1;
    repeat (6) @(posedge clk);
    rd(REG_STATUS, 32'h3, 32'h3);
    wr(REG_STATUS, 32'h00000002);
    rd(REG_STATUS, 32'h3, 32'h1);
    peer.acc = 1'b0;
    repeat (6) @(posedge clk);
    rd(REG_STATUS, 32'h3, 32'h2);
    conclude();
  end

  // watchdog, about four times the expected run
  initial begin
    #1000000;
    n_errors++;
    conclude();
  end
endmodule // tb
